// ==== jlc_map.svh ====
// register offsets, field positions, reset values and mode constants
`ifndef JLC_MAP_SVH
`define JLC_MAP_SVH
`define JLC_ADDR_LANE_PD     12'h201
`define JLC_ADDR_LINK_CTRL   12'h300
`define JLC_ADDR_SUBCLASS    12'h301
`define JLC_ADDR_MODE        12'h310
`define JLC_ADDR_OPTIONS     12'h311
`define JLC_ADDR_DAC_LO      12'h312
`define JLC_ADDR_DAC_HI      12'h313
`define JLC_ADDR_INTERP      12'h314
`define JLC_ADDR_LINK_RST    12'h315
`define JLC_ADDR_STATUS      12'h316
`define JLC_ADDR_CHECKSUM    12'h317
`define JLC_ADDR_CFG_FIRST   12'h450
`define JLC_ADDR_CFG_LAST    12'h45A
`define JLC_CFG_COUNT        11
`define JLC_BIT_CHECKSUM     6
`define JLC_BIT_TWO_LINK     3
`define JLC_BIT_LINK_SEL     2
`define JLC_BIT_SCRAMBLE     0
`define JLC_BIT_K16          1
`define JLC_BIT_VER_LO       2
`define JLC_BIT_VER_HI       4
`define JLC_BIT_EQ           7
`define JLC_MODE_8           4'h8
`define JLC_MODE_9           4'h9
`define JLC_MODE_10          4'hA
`define JLC_MODE_11          4'hB
`define JLC_MODE_12          4'hC
`define JLC_MODE_13          4'hD
`define JLC_RST_MODE         4'h8
`define JLC_RST_DAC          16'h0640
`define JLC_RST_EQ_OPTIONS   8'h80
`define JLC_INTERP_1X        8'h00
`define JLC_INTERP_2X        8'h01
`define JLC_INTERP_4X        8'h03
`define JLC_INTERP_8X        8'h04
`define JLC_LANE_MULT        21'h000014
`define JLC_RATE_MIN         21'h0005A0
`define JLC_RATE_R1_MAX      21'h000C1C
`define JLC_RATE_R2_MAX      21'h001838
`define JLC_RATE_MAX         21'h003070
`define JLC_N_MINUS1         8'h0F
`define JLC_K32_MINUS1       5'h1F
`define JLC_K16_MINUS1       5'h0F
`define JLC_PD_BOTH          3'h5
`define JLC_PD_ONE           3'h7
`define JLC_LANES_8          8'h0F
`define JLC_LANES_9          8'h03
`define JLC_LANES_10         8'h01
`define JLC_LANES_11         8'hFF
`define JLC_LANES_12         8'h33
`define JLC_LANES_13         8'h11
`endif

// ==== jlc_pkg.sv ====
// types shared by the receive link configuration logic
package jlc_pkg;
  typedef struct packed {
    logic [1:0] l_log2;
    logic [1:0] s_minus1;
    logic [1:0] f_octets;
    logic [4:0] k_minus1;
    logic       two_conv;
  } jlc_link_params_t;

  typedef struct packed {
    logic       halfrate;
    logic       oversample;
    logic [1:0] divider;
  } jlc_serdes_t;
endpackage

// ==== jlc_rx_config.sv ====
// receive link configuration: mode decode, masks, checksum, serdes clocks
`include "jlc_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - modes 8-10: one converter, 4/2/1 lanes
// - modes 11-13 programmed as one converter, halved lanes
// - modes 8 and 11 force bypass interpolation
// - lane rate from dac rate, within limits
// - high density set when one octet
// - resolution and bits per sample are 16
// - 32 frames per multiframe; 16 selectable in modes 10,13
// - two link option gives separately resettable links
// - scrambling setting enables descrambler
// - link select steers per-link configuration writes
// - lane enable and deskew masks, thermometer within each group of four lanes
// - lane power-down bit switches lane off
// - checksum select picks fields or registers
// - field checksum sums minus-one fields and flags
// - register checksum sums configuration bytes
// - subclass selects deterministic latency, needs sync
// - converter power-down 5 for two, 7 one
// - serdes clock settings follow lane rate
// - equalizer select chooses low power or long reach
module jlc_rx_config #(
  parameter int LANES = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  input  wire logic [11:0]      reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  output logic      [7:0]       reg_rdata_out,
  output logic                  reg_rvalid_out,
  output logic      [LANES-1:0] lane_enable_out,
  output logic      [LANES-1:0] lane_deskew_out,
  output logic      [LANES-1:0] lane_power_down_out,
  output logic      [1:0]       link_active_out,
  output logic                  descramble_en_out,
  output logic                  high_density_flag_out,
  output logic                  deterministic_latency_out,
  output logic      [2:0]       converter_power_down_out,
  output logic                  serdes_halfrate_out,
  output logic                  cdr_oversample_out,
  output logic      [1:0]       serdes_pll_divider_out,
  output logic                  equalizer_select_out,
  output logic                  lane_rate_ok_out,
  output logic      [7:0]       first_lane_checksum_out
);

  logic [LANES-1:0]    lane_power_down_mask;
  logic                checksum_select;
  logic                two_link_enable;
  logic                link_select;
  logic [1:0]          subclass;
  logic [3:0]          mode;
  logic [7:0]          options;
  logic [15:0]         dac_rate_mhz;
  logic [7:0]          interp;
  logic [1:0]          link_reset;
  logic [7:0]          cfg_bank [2][`JLC_CFG_COUNT];
  logic [3:0]          cfg_idx;
  logic                cfg_hit;
  logic [7:0]          interp_eff;
  logic [1:0]          interp_log2;
  jlc_pkg::jlc_link_params_t params;
  logic [7:0]          lane_mask;
  logic [20:0]         lane_rate_mbps;
  jlc_pkg::jlc_serdes_t next_serdes;
  logic [7:0]          field_sum;
  logic [7:0]          reg_sum;
  logic [7:0]          next_rdata;
  logic                params_match;

  assign cfg_idx = 4'(reg_addr_in - `JLC_ADDR_CFG_FIRST);
  assign cfg_hit = (reg_addr_in >= `JLC_ADDR_CFG_FIRST)
                && (reg_addr_in <= `JLC_ADDR_CFG_LAST);

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      lane_power_down_mask <= '0;
    end
    else if (reg_wr_in && reg_addr_in == `JLC_ADDR_LANE_PD)
    begin
      lane_power_down_mask <= reg_wdata_in[LANES-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      checksum_select <= 1'b0;
      two_link_enable <= 1'b0;
      link_select     <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == `JLC_ADDR_LINK_CTRL)
    begin
      checksum_select <= reg_wdata_in[`JLC_BIT_CHECKSUM];
      two_link_enable <= reg_wdata_in[`JLC_BIT_TWO_LINK];
      link_select     <= reg_wdata_in[`JLC_BIT_LINK_SEL];
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      subclass     <= 2'h0;
      mode         <= `JLC_RST_MODE;
      options      <= `JLC_RST_EQ_OPTIONS;
      dac_rate_mhz <= `JLC_RST_DAC;
      interp       <= `JLC_INTERP_1X;
      link_reset   <= 2'h0;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `JLC_ADDR_SUBCLASS: subclass <= reg_wdata_in[1:0];
        `JLC_ADDR_MODE:
        begin
          // undefined mode numbers are dropped to keep a legal setup
          if (reg_wdata_in[3:0] >= `JLC_MODE_8
              && reg_wdata_in[3:0] <= `JLC_MODE_13
              && reg_wdata_in[7:4] == 4'h0)
          begin
            mode <= reg_wdata_in[3:0];
          end
        end
        `JLC_ADDR_OPTIONS:  options <= reg_wdata_in;
        `JLC_ADDR_DAC_LO:   dac_rate_mhz[7:0] <= reg_wdata_in;
        `JLC_ADDR_DAC_HI:   dac_rate_mhz[15:8] <= reg_wdata_in;
        `JLC_ADDR_INTERP:   interp <= reg_wdata_in;
        `JLC_ADDR_LINK_RST: link_reset <= reg_wdata_in[1:0];
        default:            link_reset <= link_reset;
      endcase
    end
  end

  // one bank per link; the selected link takes the write
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int b = 0; b < 2; b++)
      begin
        for (int i = 0; i < `JLC_CFG_COUNT; i++)
        begin
          cfg_bank[b][i] <= 8'h00;
        end
      end
    end
    else if (reg_wr_in && cfg_hit)
    begin
      cfg_bank[link_select][cfg_idx] <= reg_wdata_in;
    end
  end

  // the stored code is kept; only the effective factor is clamped
  always_comb
  begin
    interp_eff = interp;
    if (mode == `JLC_MODE_8 || mode == `JLC_MODE_11)
    begin
      interp_eff = `JLC_INTERP_1X;
    end
    case (interp_eff)
      `JLC_INTERP_2X: interp_log2 = 2'd1;
      `JLC_INTERP_4X: interp_log2 = 2'd2;
      `JLC_INTERP_8X: interp_log2 = 2'd3;
      default:        interp_log2 = 2'd0;
    endcase
  end

  // receive side always programs one converter per link
  always_comb
  begin
    params.two_conv = 1'b0;
    params.k_minus1 = `JLC_K32_MINUS1;
    case (mode)
      `JLC_MODE_8:
      begin
        params.l_log2 = 2'd2;
        params.s_minus1 = 2'd1;
        params.f_octets = 2'd1;
        lane_mask = `JLC_LANES_8;
      end
      `JLC_MODE_9:
      begin
        params.l_log2 = 2'd1;
        params.s_minus1 = 2'd0;
        params.f_octets = 2'd1;
        lane_mask = `JLC_LANES_9;
      end
      `JLC_MODE_10:
      begin
        params.l_log2 = 2'd0;
        params.s_minus1 = 2'd0;
        params.f_octets = 2'd2;
        lane_mask = `JLC_LANES_10;
      end
      `JLC_MODE_11:
      begin
        params.l_log2 = 2'd2;
        params.s_minus1 = 2'd1;
        params.f_octets = 2'd1;
        params.two_conv = 1'b1;
        lane_mask = `JLC_LANES_11;
      end
      `JLC_MODE_12:
      begin
        params.l_log2 = 2'd1;
        params.s_minus1 = 2'd0;
        params.f_octets = 2'd1;
        params.two_conv = 1'b1;
        lane_mask = `JLC_LANES_12;
      end
      default:
      begin
        params.l_log2 = 2'd0;
        params.s_minus1 = 2'd0;
        params.f_octets = 2'd2;
        params.two_conv = 1'b1;
        lane_mask = `JLC_LANES_13;
      end
    endcase
    if ((mode == `JLC_MODE_10 || mode == `JLC_MODE_13)
        && options[`JLC_BIT_K16])
    begin
      params.k_minus1 = `JLC_K16_MINUS1;
    end
  end

  // lane rate in Mbps: 20 x dac / interp / lanes, one converter
  assign lane_rate_mbps = (21'(dac_rate_mhz) * `JLC_LANE_MULT)
                          >> (interp_log2 + 3'(params.l_log2));

  always_comb
  begin
    // first matching row wins where the ranges overlap
    if (lane_rate_mbps <= `JLC_RATE_R1_MAX)
    begin
      next_serdes = '{halfrate: 1'b0, oversample: 1'b1, divider: 2'd2};
    end
    else if (lane_rate_mbps <= `JLC_RATE_R2_MAX)
    begin
      next_serdes = '{halfrate: 1'b0, oversample: 1'b0, divider: 2'd1};
    end
    else
    begin
      next_serdes = '{halfrate: 1'b1, oversample: 1'b0, divider: 2'd0};
    end
  end

  always_comb
  begin
    field_sum = 8'(params.l_log2 == 2'd2 ? 2'h3 : params.l_log2)
              + 8'(params.k_minus1) + `JLC_N_MINUS1 + `JLC_N_MINUS1
              + 8'(params.s_minus1) + 8'(options[`JLC_BIT_SCRAMBLE])
              + 8'(params.f_octets == 2'd1) + 8'(subclass)
              + 8'(options[`JLC_BIT_VER_HI:`JLC_BIT_VER_LO]);
    reg_sum = 8'h00;
    for (int i = 0; i < `JLC_CFG_COUNT; i++)
    begin
      reg_sum = reg_sum + cfg_bank[link_select][i];
    end
    params_match = 1'b1;
    for (int i = 0; i < `JLC_CFG_COUNT; i++)
    begin
      if (cfg_bank[0][i] != cfg_bank[1][i])
      begin
        params_match = 1'b0;
      end
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    if (cfg_hit)
    begin
      next_rdata = cfg_bank[link_select][cfg_idx];
    end
    else
    begin
      case (reg_addr_in)
        `JLC_ADDR_LANE_PD:   next_rdata = 8'(lane_power_down_mask);
        `JLC_ADDR_LINK_CTRL: next_rdata = {1'b0, checksum_select, 2'b00,
                                           two_link_enable, link_select,
                                           two_link_enable, 1'b1};
        `JLC_ADDR_SUBCLASS:  next_rdata = {6'h00, subclass};
        `JLC_ADDR_MODE:      next_rdata = {4'h0, mode};
        `JLC_ADDR_OPTIONS:   next_rdata = options;
        `JLC_ADDR_DAC_LO:    next_rdata = dac_rate_mhz[7:0];
        `JLC_ADDR_DAC_HI:    next_rdata = dac_rate_mhz[15:8];
        `JLC_ADDR_INTERP:    next_rdata = interp_eff;
        `JLC_ADDR_LINK_RST:  next_rdata = {6'h00, link_reset};
        `JLC_ADDR_STATUS:    next_rdata = {6'h00, params_match,
                                           lane_rate_ok_out};
        `JLC_ADDR_CHECKSUM:  next_rdata = first_lane_checksum_out;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      reg_rdata_out  <= reg_rd_in ? next_rdata : 8'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      lane_enable_out           <= '0;
      lane_deskew_out           <= '0;
      lane_power_down_out       <= '0;
      link_active_out           <= 2'h0;
      descramble_en_out         <= 1'b0;
      high_density_flag_out     <= 1'b0;
      deterministic_latency_out <= 1'b0;
      converter_power_down_out  <= `JLC_PD_ONE;
      serdes_halfrate_out       <= 1'b0;
      cdr_oversample_out        <= 1'b0;
      serdes_pll_divider_out    <= 2'd0;
      equalizer_select_out      <= 1'b0;
      lane_rate_ok_out          <= 1'b0;
      first_lane_checksum_out   <= 8'h00;
    end
    else
    begin
      lane_enable_out     <= lane_mask[LANES-1:0];
      lane_deskew_out     <= lane_mask[LANES-1:0];
      lane_power_down_out <= lane_power_down_mask;
      // link 1 runs only with two links; each has its own reset
      link_active_out <= {two_link_enable & ~link_reset[1],
                          ~link_reset[0]};
      descramble_en_out <= options[`JLC_BIT_SCRAMBLE];
      high_density_flag_out <= (params.f_octets == 2'd1);
      deterministic_latency_out <= (subclass == 2'h1);
      converter_power_down_out <= (two_link_enable || params.two_conv)
                                  ? `JLC_PD_BOTH : `JLC_PD_ONE;
      serdes_halfrate_out    <= next_serdes.halfrate;
      cdr_oversample_out     <= next_serdes.oversample;
      serdes_pll_divider_out <= next_serdes.divider;
      equalizer_select_out   <= options[`JLC_BIT_EQ];
      lane_rate_ok_out <= (lane_rate_mbps >= `JLC_RATE_MIN)
                       && (lane_rate_mbps <= `JLC_RATE_MAX);
      first_lane_checksum_out <= checksum_select ? reg_sum
                                                 : field_sum;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence scramble_on_write;
    reg_wr_in && reg_addr_in == `JLC_ADDR_OPTIONS
      && reg_wdata_in[`JLC_BIT_SCRAMBLE];
  endsequence

  sequence pd_mask_write;
    reg_wr_in && reg_addr_in == `JLC_ADDR_LANE_PD;
  endsequence

  lane_mode_eight_a: assert property (
    mode == `JLC_MODE_8 |=> lane_enable_out == `JLC_LANES_8)
    else $error("mode 8 lane mask wrong");
  lane_mode_twelve_a: assert property (
    mode == `JLC_MODE_12 |=> lane_deskew_out == `JLC_LANES_12)
    else $error("mode 12 deskew mask wrong");
  bypass_only_a: assert property (
    (mode == `JLC_MODE_8 || mode == `JLC_MODE_11)
      |-> interp_log2 == 2'd0)
    else $error("interpolation not bypassed");
  high_density_a: assert property (
    (mode == `JLC_MODE_10 || mode == `JLC_MODE_13)
      |=> !high_density_flag_out)
    else $error("high density set with two octets");
  descramble_follow_a: assert property (
    scramble_on_write |-> ##2 descramble_en_out)
    else $error("descrambler not enabled");
  pd_mask_write_a: assert property (
    pd_mask_write |-> ##2
      lane_power_down_out == $past(reg_wdata_in[LANES-1:0], 2))
    else $error("lane power-down mask not applied");
  conv_pd_single_a: assert property (
    (!two_link_enable && mode <= `JLC_MODE_10)
      |=> converter_power_down_out == `JLC_PD_ONE)
    else $error("single converter power-down wrong");
  frames_fixed_a: assert property (
    (mode == `JLC_MODE_9 || mode == `JLC_MODE_12)
      |-> params.k_minus1 == `JLC_K32_MINUS1)
    else $error("frames per multiframe not 32");
  serdes_high_a: assert property (
    lane_rate_mbps > `JLC_RATE_R2_MAX |=> serdes_halfrate_out
      && serdes_pll_divider_out == 2'd0)
    else $error("high rate serdes setting wrong");
  link_one_off_a: assert property (
    !two_link_enable |=> !link_active_out[1])
    else $error("link 1 active in single link");

endmodule
`default_nettype wire

// ==== jlc_tx_model.sv ====
// transmitter side model: mirrored link fields and its own checksum
`timescale 1ns/1ps
`default_nettype none
module jlc_tx_model (
  input  wire logic [3:0]  mode_in,
  input  wire logic        scramble_in,
  input  wire logic        k16_in,
  input  wire logic [1:0]  subclass_in,
  input  wire logic [2:0]  version_in,
  input  wire logic        checksum_select_in,
  input  wire logic [87:0] cfg_bytes_in,
  output logic      [3:0]  tx_conv_out,
  output logic      [3:0]  tx_lanes_out,
  output logic      [7:0]  checksum_out
);
  logic [7:0] rx_l;
  logic [7:0] s;
  logic [7:0] hd;
  logic [7:0] k;
  logic [7:0] sum;
  always_comb
  begin
    rx_l = (mode_in == 4'h8 || mode_in == 4'hB) ? 8'h04 :
           (mode_in == 4'h9 || mode_in == 4'hC) ? 8'h02 : 8'h01;
    s = (rx_l == 8'h04) ? 8'h02 : 8'h01;
    hd = (rx_l == 8'h01) ? 8'h00 : 8'h01;
    k = (k16_in && rx_l == 8'h01) ? 8'h10 : 8'h20;
    // tx side carries the true converter and lane counts
    tx_conv_out = (mode_in > 4'hA) ? 4'h2 : 4'h1;
    tx_lanes_out = (mode_in > 4'hA) ? rx_l[3:0] << 1 : rx_l[3:0];
    sum = 8'h00;
    for (int i = 0; i < 11; i++)
    begin
      sum = sum + cfg_bytes_in[8*i +: 8];
    end
    if (!checksum_select_in)
    begin
      sum = (rx_l - 8'h01) + (k - 8'h01) + 8'h0F + 8'h0F + (s - 8'h01)
          + {7'h00, scramble_in} + hd + {6'h00, subclass_in}
          + {5'h00, version_in};
    end
    checksum_out = sum;
  end
endmodule
`default_nettype wire

// ==== jlc_rx_config_tb_top.sv ====
// self-checking bench for the receive link configuration block
`timescale 1ns/1ps
`default_nettype none
module jlc_rx_config_tb_top;
  logic        core_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [7:0]  lane_en;
  logic [7:0]  deskew;
  logic [7:0]  lane_pd;
  logic [1:0]  link_act;
  logic        descr;
  logic        hd;
  logic        det;
  logic [2:0]  conv_pd;
  logic        hr;
  logic        ovs;
  logic [1:0]  div;
  logic        eq;
  logic        rate_ok;
  logic [7:0]  csum;
  logic [3:0]  m_mode = 4'h8;
  logic [6:0]  m_opt = 7'h00;
  logic [1:0]  m_sub = 2'h0;
  logic        m_csel = 1'b0;
  logic [87:0] m_cfg = 88'h0;
  logic [3:0]  tx_conv;
  logic [3:0]  tx_lanes;
  logic [7:0]  tx_csum;
  logic [7:0]  v;
  int          n_errors = 0;
  int          compares = 0;

  always #4 core_clk_in = ~core_clk_in;

  jlc_rx_config i_jlc_rx_config (
    .core_clk_in               (core_clk_in),
    .resetn_in                 (resetn_in),
    .reg_wr_in                 (reg_wr_in),
    .reg_rd_in                 (reg_rd_in),
    .reg_addr_in               (reg_addr_in),
    .reg_wdata_in              (reg_wdata_in),
    .reg_rdata_out             (rdata),
    .reg_rvalid_out            (rvalid),
    .lane_enable_out           (lane_en),
    .lane_deskew_out           (deskew),
    .lane_power_down_out       (lane_pd),
    .link_active_out           (link_act),
    .descramble_en_out         (descr),
    .high_density_flag_out     (hd),
    .deterministic_latency_out (det),
    .converter_power_down_out  (conv_pd),
    .serdes_halfrate_out       (hr),
    .cdr_oversample_out        (ovs),
    .serdes_pll_divider_out    (div),
    .equalizer_select_out      (eq),
    .lane_rate_ok_out          (rate_ok),
    .first_lane_checksum_out   (csum)
  );

  jlc_tx_model i_jlc_tx_model (
    .mode_in            (m_mode),
    .scramble_in        (m_opt[0]),
    .k16_in             (m_opt[1]),
    .subclass_in        (m_sub),
    .version_in         (m_opt[4:2]),
    .checksum_select_in (m_csel),
    .cfg_bytes_in       (m_cfg),
    .tx_conv_out        (tx_conv),
    .tx_lanes_out       (tx_lanes),
    .checksum_out       (tx_csum)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    step();
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    step();
    reg_wr_in = 1'b0;
  endtask

  // registered answer: rvalid lands on the edge after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    step();
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    step();
    reg_rd_in = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask

  task automatic t_reset();
    // outputs are unknown until the first edge under reset
    repeat (3) @(posedge core_clk_in);
    #1;
    chk({5'h00, conv_pd}, 8'h07);
    resetn_in = 1'b1;
    step();
    chk(lane_en, 8'h0F);
    chk({6'h00, hd, eq}, 8'h03);
    chk({4'h0, hr, ovs, div}, 8'h08);
    chk({7'h00, rate_ok}, 8'h01);
    chk({5'h00, conv_pd}, 8'h07);
    rd(12'h310, v);
    chk(v, 8'h08);
    rd(12'h316, v);
    chk(v, 8'h03);
    $display("test reset done");
  endtask

  task automatic t_modes();
    logic [7:0] masks [6];
    masks = '{8'h0F, 8'h03, 8'h01, 8'hFF, 8'h33, 8'h11};
    for (int i = 0; i < 6; i++)
    begin
      m_mode = 4'h8 + 4'(i);
      wr(12'h310, 8'h08 + 8'(i));
      step();
      chk(lane_en, masks[i]);
      chk(8'($countones(lane_en)), {4'h0, tx_lanes});
      chk({4'h0, tx_conv}, (i < 3) ? 8'h01 : 8'h02);
      chk(deskew, masks[i]);
      chk({7'h00, hd}, (i % 3 == 2) ? 8'h00 : 8'h01);
      chk({5'h00, conv_pd}, (i < 3) ? 8'h07 : 8'h05);
    end
    wr(12'h310, 8'h07);
    rd(12'h310, v);
    chk(v, 8'h0D);
    $display("test modes done");
  endtask

  task automatic t_interp();
    wr(12'h310, 8'h08);
    wr(12'h314, 8'h01);
    rd(12'h314, v);
    chk(v, 8'h00);
    wr(12'h310, 8'h0B);
    rd(12'h314, v);
    chk(v, 8'h00);
    wr(12'h310, 8'h09);
    rd(12'h314, v);
    chk(v, 8'h01);
    $display("test interp done");
  endtask

  // exp holds ok, halfrate, oversample, divider
  task automatic rate_case(input logic [7:0] m, input logic [15:0] dac,
                           input logic [7:0] code, input logic [4:0] exp);
    wr(12'h310, m);
    wr(12'h312, dac[7:0]);
    wr(12'h313, dac[15:8]);
    wr(12'h314, code);
    step();
    chk({7'h00, rate_ok}, {7'h00, exp[4]});
    if (exp[4])
    begin
      chk({4'h0, hr, ovs, div}, {4'h0, exp[3:0]});
    end
    rd(12'h316, v);
    chk({7'h00, v[0]}, {7'h00, exp[4]});
  endtask

  task automatic t_rate();
    rate_case(8'h09, 16'h0640, 8'h01, 5'h18);
    rate_case(8'h09, 16'h0640, 8'h03, 5'h11);
    rate_case(8'h09, 16'h0640, 8'h04, 5'h16);
    rate_case(8'h0A, 16'h009B, 8'h00, 5'h16);
    rate_case(8'h0A, 16'h0136, 8'h00, 5'h11);
    rate_case(8'h0A, 16'h026C, 8'h00, 5'h18);
    rate_case(8'h0A, 16'h026D, 8'h00, 5'h00);
    rate_case(8'h09, 16'h0078, 8'h04, 5'h00);
    $display("test rate done");
  endtask

  task automatic t_link();
    wr(12'h300, 8'h08);
    step();
    chk({6'h00, link_act}, 8'h03);
    chk({5'h00, conv_pd}, 8'h05);
    rd(12'h300, v);
    chk(v, 8'h0B);
    wr(12'h315, 8'h02);
    step();
    chk({6'h00, link_act}, 8'h01);
    wr(12'h315, 8'h01);
    step();
    chk({6'h00, link_act}, 8'h02);
    wr(12'h315, 8'h00);
    wr(12'h450, 8'h5A);
    wr(12'h300, 8'h0C);
    wr(12'h450, 8'hA5);
    rd(12'h450, v);
    chk(v, 8'hA5);
    rd(12'h316, v);
    chk({7'h00, v[1]}, 8'h00);
    wr(12'h300, 8'h00);
    rd(12'h450, v);
    chk(v, 8'h5A);
    chk({6'h00, link_act}, 8'h01);
    chk({5'h00, conv_pd}, 8'h07);
    $display("test link done");
  endtask

  task automatic t_options();
    wr(12'h311, 8'h01);
    step();
    chk({6'h00, descr, eq}, 8'h02);
    wr(12'h311, 8'h80);
    step();
    chk({6'h00, descr, eq}, 8'h01);
    wr(12'h301, 8'h01);
    step();
    chk({7'h00, det}, 8'h01);
    wr(12'h301, 8'h00);
    step();
    chk({7'h00, det}, 8'h00);
    wr(12'h201, 8'hCC);
    step();
    chk(lane_pd, 8'hCC);
    rd(12'h201, v);
    chk(v, 8'hCC);
    rd(12'h3FF, v);
    chk(v, 8'h00);
    $display("test options done");
  endtask

  task automatic t_checksum();
    m_mode = 4'hA;
    m_opt = 7'h07;
    m_sub = 2'h1;
    wr(12'h310, 8'h0A);
    wr(12'h311, 8'h07);
    wr(12'h301, 8'h01);
    step();
    chk(csum, tx_csum);
    // the frame length option must be ignored outside modes 10 and 13
    m_mode = 4'h9;
    wr(12'h310, 8'h09);
    step();
    chk(csum, tx_csum);
    for (int i = 0; i < 11; i++)
    begin
      m_cfg[8*i +: 8] = 8'h11 * 8'(i) + 8'h07;
      wr(12'h450 + 12'(i), m_cfg[8*i +: 8]);
    end
    m_csel = 1'b1;
    wr(12'h300, 8'h40);
    step();
    chk(csum, tx_csum);
    rd(12'h317, v);
    chk(v, tx_csum);
    $display("test checksum done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_modes();
    t_interp();
    t_rate();
    t_link();
    t_options();
    t_checksum();
    conclude();
  end

  // the whole sequence needs well under two thousand cycles
  initial
  begin
    #40000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
